// ---- src/iox_regs.vh ----
// Register offsets, reset values, address pattern and timing constants
`ifndef IOX_REGS_VH
`define IOX_REGS_VH
`define IOX_REG_INPUT_LEVEL 2'h0
`define IOX_REG_OUTPUT_LATCH 2'h1
`define IOX_REG_POLARITY 2'h2
`define IOX_REG_DIRECTION 2'h3
`define IOX_RST_OUTPUT_LATCH 8'hff
`define IOX_RST_POLARITY 8'h00
`define IOX_RST_DIRECTION 8'hff
`define IOX_RST_POINTER 8'h00
`define IOX_ADDR_UPPER 4'h7
`define IOX_FILTER_LEN 3'h3
`define IOX_FIFO_WIDTH 8
`define IOX_FIFO_DEPTH 16
`define IOX_FIFO_AW 4
`endif

// ---- src/iox_fifo.v ----
// Small synchronous FIFO with registered read data
`timescale 1ns/1ps
`include "iox_regs.vh"
module iox_fifo
#(
    parameter WIDTH = `IOX_FIFO_WIDTH,
    parameter DEPTH = `IOX_FIFO_DEPTH,
    parameter AW = `IOX_FIFO_AW
)
(
    input wire i_clock,
    input wire i_reset_n,
    input wire i_enable,
    input wire i_clear,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output reg [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    reg out_full;
    wire push;
    wire pop;
    wire load;
    localparam [AW:0] DEPTH_W = DEPTH;
    // Output register shares the depth, so at most DEPTH words are held
    assign o_in_ready = ((count + {{AW{1'b0}}, out_full}) != DEPTH_W);
    assign o_out_valid = out_full;
    assign push = i_in_valid && o_in_ready;
    assign load = (count != {(AW+1){1'b0}}) && (!out_full || i_out_ready);
    assign pop = out_full && i_out_ready;
    always @(posedge i_clock)
    begin
        if (i_enable && push)
            mem[wr_ptr] <= i_in_data;
    end
    always @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            out_full <= 1'b0;
            o_out_data <= {WIDTH{1'b0}};
        end
        else if (i_enable)
        begin
            if (i_clear)
            begin
                wr_ptr <= {AW{1'b0}};
                rd_ptr <= {AW{1'b0}};
                count <= {(AW+1){1'b0}};
                out_full <= 1'b0;
            end
            else
            begin
                if (push)
                    wr_ptr <= wr_ptr + 1'b1;
                if (load)
                begin
                    o_out_data <= mem[rd_ptr];
                    rd_ptr <= rd_ptr + 1'b1;
                    out_full <= 1'b1;
                end
                else if (pop)
                    out_full <= 1'b0;
                if (push && !load)
                    count <= count + 1'b1;
                else if (!push && load)
                    count <= count - 1'b1;
            end
        end
    end
endmodule

// ---- src/iox_expander.v ----
// I2C target with an 8-bit I/O port behind four byte registers
// Behaviour
// - Acknowledge matching address on ninth pulse
// - One bit per pulse, data stable high
// - Transmitter releases data for acknowledge
// - Acknowledge every received byte
// - Master nacks last byte, device releases
// - Address is 0111 plus three selects
// - Direction 1 read, 0 write
// - First written byte sets the pointer
// - Pointer changes only on new command
// - Input level read-only, shows pin levels
// - Latch drives outputs, reads return latch
// - Polarity bit inverts reported input
// - Direction 1 input, 0 output
// - Write: address, command, data bytes
// - Read after repeated Start repeats register
// - Capture pins at acknowledge rising edge
// - Interrupt when input differs from capture
// - Interrupt clears on input read acknowledge; the pins are recaptured on the acknowledge of a read of any register
// - Reset restores defaults and idle
`timescale 1ns/1ps
`include "iox_regs.vh"
module iox_expander
(
    input wire i_clock,
    input wire i_reset_n,
    input wire i_enable,
    input wire i_scl,
    input wire i_sda,
    output wire o_sda_out,
    output wire o_sda_oe_n,
    input wire i_addr_select_bit0,
    input wire i_addr_select_bit1,
    input wire i_addr_select_bit2,
    input wire [7:0] i_port_pin,
    output wire [7:0] o_port_pin,
    output wire [7:0] o_port_pin_oe_n,
    output wire o_int_out,
    output wire o_int_oe_n,
    output wire o_wr_valid,
    input wire i_wr_ready,
    output wire [7:0] o_wr_data
);
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_ADDR_ACK = 3'd2;
    localparam ST_WRITE = 3'd3;
    localparam ST_WRITE_ACK = 3'd4;
    localparam ST_READ = 3'd5;
    localparam ST_READ_ACK = 3'd6;

    reg [1:0] scl_sync;
    reg [1:0] sda_sync;
    reg [7:0] pin_meta;
    reg [7:0] pin_level;
    reg [2:0] sel_meta;
    reg [2:0] sel_level;
    reg [2:0] scl_cnt;
    reg [2:0] sda_cnt;
    reg scl_f;
    reg sda_f;
    reg scl_prev;
    reg sda_prev;
    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shift;
    reg rw_bit;
    reg first_byte;
    reg [2:0] addr_sel;
    reg sda_low;
    reg [7:0] pointer;
    reg [7:0] output_latch;
    reg [7:0] input_polarity_invert;
    reg [7:0] pin_direction;
    reg [7:0] input_level;
    reg [7:0] tx_byte;
    reg loaded;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire [7:0] pin_report;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire fifo_push;
    wire [7:0] sel_value;

    // Data from the target register; only the input level carries polarity
    function [7:0] reg_value;
        input [1:0] sel;
        input [7:0] inl;
        input [7:0] outl;
        input [7:0] pol;
        input [7:0] dir;
        begin
            if (sel == `IOX_REG_INPUT_LEVEL)
                reg_value = inl;
            else if (sel == `IOX_REG_OUTPUT_LATCH)
                reg_value = outl;
            else if (sel == `IOX_REG_POLARITY)
                reg_value = pol;
            else
                reg_value = dir;
        end
    endfunction

    // Two-stage synchronisers; first stage feeds only the second
    always @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            scl_sync <= 2'b11;
            sda_sync <= 2'b11;
            pin_meta <= 8'h00;
            pin_level <= 8'h00;
            sel_meta <= 3'h0;
            sel_level <= 3'h0;
        end
        else if (i_enable)
        begin
            scl_sync <= {scl_sync[0], i_scl};
            sda_sync <= {sda_sync[0], i_sda};
            pin_meta <= i_port_pin;
            pin_level <= pin_meta;
            sel_meta <= {i_addr_select_bit2, i_addr_select_bit1,
                i_addr_select_bit0};
            sel_level <= sel_meta;
        end
    end

    // Glitch filter: a level must persist before it is accepted
    always @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            scl_cnt <= 3'h0;
            sda_cnt <= 3'h0;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end
        else if (i_enable)
        begin
            if (scl_sync[1] == scl_f)
                scl_cnt <= 3'h0;
            else if (scl_cnt == `IOX_FILTER_LEN)
            begin
                scl_f <= scl_sync[1];
                scl_cnt <= 3'h0;
            end
            else
                scl_cnt <= scl_cnt + 3'h1;
            if (sda_sync[1] == sda_f)
                sda_cnt <= 3'h0;
            else if (sda_cnt == `IOX_FILTER_LEN)
            begin
                sda_f <= sda_sync[1];
                sda_cnt <= 3'h0;
            end
            else
                sda_cnt <= sda_cnt + 3'h1;
            scl_prev <= scl_f;
            sda_prev <= sda_f;
        end
    end

    assign scl_rise = scl_f && !scl_prev;
    assign scl_fall = !scl_f && scl_prev;
    assign start_det = scl_f && scl_prev && sda_prev && !sda_f;
    assign stop_det = scl_f && scl_prev && !sda_prev && sda_f;
    assign pin_report = pin_level ^ input_polarity_invert;
    assign sel_value = reg_value(pointer[1:0], input_level, output_latch,
        input_polarity_invert, pin_direction);
    assign fifo_push = (state == ST_WRITE) && scl_fall &&
        (bit_cnt == 4'd8) && !first_byte;

    // Serial engine; data line only changes while the clock is low
    always @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            rw_bit <= 1'b0;
            first_byte <= 1'b0;
            addr_sel <= 3'h0;
            sda_low <= 1'b0;
            pointer <= `IOX_RST_POINTER;
            tx_byte <= 8'h00;
            input_level <= 8'h00;
            loaded <= 1'b0;
        end
        else if (i_enable)
        begin
            if (!loaded)
            begin
                input_level <= pin_report;
                loaded <= 1'b1;
            end
            if (stop_det)
            begin
                state <= ST_IDLE;
                sda_low <= 1'b0;
            end
            else if (start_det)
            begin
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_low <= 1'b0;
                addr_sel <= sel_level;
            end
            else
            begin
                case (state)
                    ST_ADDR:
                    begin
                        if (scl_rise)
                        begin
                            shift <= {shift[6:0], sda_f};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        else if (scl_fall && bit_cnt == 4'd8)
                        begin
                            if (shift[7:1] == {`IOX_ADDR_UPPER, addr_sel})
                            begin
                                sda_low <= 1'b1;
                                rw_bit <= shift[0];
                                state <= ST_ADDR_ACK;
                            end
                            else
                                state <= ST_IDLE;
                        end
                    end
                    ST_ADDR_ACK:
                    begin
                        // Fresh pin capture so the first byte is current
                        if (scl_rise && rw_bit)
                            input_level <= pin_report;
                        else if (scl_fall)
                        begin
                            bit_cnt <= 4'h0;
                            if (rw_bit)
                            begin
                                tx_byte <= sel_value;
                                sda_low <= !sel_value[7];
                                state <= ST_READ;
                            end
                            else
                            begin
                                sda_low <= 1'b0;
                                first_byte <= 1'b1;
                                state <= ST_WRITE;
                            end
                        end
                    end
                    ST_WRITE:
                    begin
                        if (scl_rise)
                        begin
                            shift <= {shift[6:0], sda_f};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        else if (scl_fall && bit_cnt == 4'd8)
                        begin
                            if (first_byte)
                                pointer <= shift;
                            first_byte <= 1'b0;
                            sda_low <= 1'b1;
                            state <= ST_WRITE_ACK;
                        end
                    end
                    ST_WRITE_ACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_low <= 1'b0;
                            bit_cnt <= 4'h0;
                            state <= ST_WRITE;
                        end
                    end
                    ST_READ:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_cnt == 4'd7)
                            begin
                                sda_low <= 1'b0;
                                state <= ST_READ_ACK;
                            end
                            else
                            begin
                                sda_low <= !tx_byte[3'd6 - bit_cnt[2:0]];
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    ST_READ_ACK:
                    begin
                        if (scl_rise)
                        begin
                            input_level <= pin_report;
                            rw_bit <= sda_f;
                        end
                        else if (scl_fall)
                        begin
                            bit_cnt <= 4'h0;
                            if (rw_bit)
                            begin
                                sda_low <= 1'b0;
                                state <= ST_IDLE;
                            end
                            else
                            begin
                                tx_byte <= sel_value;
                                sda_low <= !sel_value[7];
                                rw_bit <= 1'b1;
                                state <= ST_READ;
                            end
                        end
                    end
                    default:
                        sda_low <= 1'b0;
                endcase
            end
        end
    end

    // Written data bytes pass the FIFO before landing in a register
    iox_fifo u_fifo
    (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_enable(i_enable),
        .i_clear(1'b0),
        .i_in_valid(fifo_push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(shift),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(i_wr_ready),
        .o_out_data(fifo_out_data)
    );
    assign o_wr_valid = fifo_out_valid;
    assign o_wr_data = fifo_out_data;

    // Drain stalls on i_wr_ready; a full FIFO drops further bytes
    always @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            output_latch <= `IOX_RST_OUTPUT_LATCH;
            input_polarity_invert <= `IOX_RST_POLARITY;
            pin_direction <= `IOX_RST_DIRECTION;
        end
        else if (i_enable && fifo_out_valid && i_wr_ready)
        begin
            if (pointer[1:0] == `IOX_REG_OUTPUT_LATCH)
                output_latch <= fifo_out_data;
            else if (pointer[1:0] == `IOX_REG_POLARITY)
                input_polarity_invert <= fifo_out_data;
            else if (pointer[1:0] == `IOX_REG_DIRECTION)
                pin_direction <= fifo_out_data;
        end
    end

    // Interrupt: input pins differing from captured value
    wire [7:0] diff = (pin_report ^ input_level) & pin_direction;
    assign o_int_out = 1'b0;
    assign o_int_oe_n = !(loaded && (diff != 8'h00));

    assign o_sda_out = 1'b0;
    assign o_sda_oe_n = !sda_low;
    assign o_port_pin = output_latch;
    assign o_port_pin_oe_n = pin_direction;
endmodule

// ---- verification/iox_expander_assertions.sv ----
// Assertions on the I/O expander ports
`timescale 1ns/1ps
module iox_expander_chk
(
    input wire i_clock,
    input wire i_reset_n,
    input wire i_scl,
    input wire i_wr_ready,
    input wire o_sda_out,
    input wire o_sda_oe_n,
    input wire [7:0] o_port_pin,
    input wire [7:0] o_port_pin_oe_n,
    input wire o_int_out,
    input wire o_int_oe_n,
    input wire o_wr_valid,
    input wire [7:0] o_wr_data
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);
    open_drain_a: assert property (!o_sda_out && !o_int_out)
        else $error("open drain output driven high");
    reset_defaults_a: assert property ($rose(i_reset_n) |->
        o_port_pin == 8'hff && o_port_pin_oe_n == 8'hff && o_sda_oe_n)
        else $error("port not at defaults after reset");
    // Drive may only move while the clock is low, else it reads as Start or Stop
    sda_steady_a: assert property (i_scl && $past(i_scl) |->
        $stable(o_sda_oe_n)) else $error("data drive moved, clock high");
    ack_hold_a: assert property ($fell(o_sda_oe_n) |=>
        !o_sda_oe_n [*8]) else $error("data pulled low too briefly");
    wr_hold_a: assert property (o_wr_valid && !i_wr_ready |=>
        o_wr_valid && $stable(o_wr_data)) else $error("pending byte lost");
    latch_apply_a: assert property ($changed(o_port_pin) |->
        $past(o_wr_valid && i_wr_ready)) else $error("latch moved unasked");
    dir_apply_a: assert property ($changed(o_port_pin_oe_n) |->
        $past(o_wr_valid && i_wr_ready)) else $error("direction moved");
    out_no_int_a: assert property (o_port_pin_oe_n == 8'h00 |->
        o_int_oe_n) else $error("interrupt from output pins");
endmodule
bind iox_expander iox_expander_chk chk
(
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_scl(i_scl),
    .i_wr_ready(i_wr_ready),
    .o_sda_out(o_sda_out),
    .o_sda_oe_n(o_sda_oe_n),
    .o_port_pin(o_port_pin),
    .o_port_pin_oe_n(o_port_pin_oe_n),
    .o_int_out(o_int_out),
    .o_int_oe_n(o_int_oe_n),
    .o_wr_valid(o_wr_valid),
    .o_wr_data(o_wr_data)
);

// ---- verification/iox_i2c_master.sv ----
// Behavioural bus master driving the two-wire link
`timescale 1ns/1ps
module iox_i2c_master
(
    output reg o_scl,
    output reg o_sda_oe_n,
    input wire i_sda
);
    initial
    begin
        o_scl = 1'b1;
        o_sda_oe_n = 1'b1;
    end
    // Long low phase covers the target's synchroniser and filter delay
    task bit_io(input b, output r);
    begin
        #400 o_sda_oe_n = b;
        #240 o_scl = 1'b1;
        #160 r = i_sda;
        #160 o_scl = 1'b0;
    end
    endtask
    task start;
    begin
        if (!o_scl)
        begin
            #400 o_sda_oe_n = 1'b1;
            #240 o_scl = 1'b1;
        end
        #333 o_sda_oe_n = 1'b0;
        #320 o_scl = 1'b0;
    end
    endtask
    task stop;
    begin
        #400 o_sda_oe_n = 1'b0;
        #240 o_scl = 1'b1;
        #320 o_sda_oe_n = 1'b1;
        #320;
    end
    endtask
    task wbyte(input [7:0] d, output ack);
        integer i;
        reg r;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    end
    endtask
    task rbyte(input last, output [7:0] d);
        integer i;
        reg r;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bit_io(1'b1, d[i]);
        bit_io(last, r);
    end
    endtask
endmodule

// ---- verification/test_i2c_eight_bit_io_expander.sv ----
// Self-checking bench for the I/O expander
`timescale 1ns/1ps
module test_i2c_eight_bit_io_expander;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg en = 1'b1;
    reg ready = 1'b1;
    reg [2:0] strap = 3'h0;
    reg [7:0] ext = 8'h5a;
    reg [31:0] seed = 32'h20e9;
    reg [7:0] mreg [0:3];
    reg [1:0] mptr = 2'h0;
    reg ack;
    reg [7:0] got, pv, nacc, base;
    reg [7:0] wq [$];
    integer fails = 0;
    integer n_tests = 0;
    integer i, k;
    wire scl, m_oe_n, d_oe_n, int_oe_n, wr_valid;
    wire [7:0] p_out, p_oe_n, wr_data;
    wire sda = m_oe_n & d_oe_n;
    wire [7:0] pin = (ext & p_oe_n) | (p_out & ~p_oe_n);
    always #20 clk = ~clk;
    iox_expander dut
    (
        .i_clock(clk),
        .i_reset_n(rst_n),
        .i_enable(en),
        .i_scl(scl),
        .i_sda(sda),
        .o_sda_out(),
        .o_sda_oe_n(d_oe_n),
        .i_addr_select_bit0(strap[0]),
        .i_addr_select_bit1(strap[1]),
        .i_addr_select_bit2(strap[2]),
        .i_port_pin(pin),
        .o_port_pin(p_out),
        .o_port_pin_oe_n(p_oe_n),
        .o_int_out(),
        .o_int_oe_n(int_oe_n),
        .o_wr_valid(wr_valid),
        .i_wr_ready(ready),
        .o_wr_data(wr_data)
    );
    iox_i2c_master m
    (
        .o_scl(scl),
        .o_sda_oe_n(m_oe_n),
        .i_sda(sda)
    );
    function [31:0] lfsr(input [31:0] s);
        lfsr = s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction
    task automatic chk(input [7:0] g, input [7:0] e);
    begin
        n_tests = n_tests + 1;
        if (g !== e)
        begin
            $display("wrong value at %0t ns: %h expected %h", $time, g, e);
            fails = fails + 1;
        end
    end
    endtask
    task stop_test;
    begin
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    task probe(input [6:0] a, input e);
    begin
        m.start();
        m.wbyte({a, 1'b0}, ack);
        m.stop();
        chk({7'h0, ack}, {7'h0, e});
    end
    endtask
    task hdr(input [7:0] cmd);
    begin
        m.start();
        m.wbyte({4'h7, strap, 1'b0}, ack);
        chk({7'h0, ack}, 8'h01);
        m.wbyte(cmd, ack);
        chk({7'h0, ack}, 8'h01);
        mptr = cmd[1:0];
    end
    endtask
    task wr(input [7:0] cmd, input integer n, input [7:0] fix, input f);
        reg [7:0] v;
    begin
        hdr(cmd);
        for (k = 0; k < n; k = k + 1)
        begin
            seed = lfsr(seed);
            v = f ? fix : seed[7:0];
            if (wq.size() < 16)
                wq.push_back(v);
            m.wbyte(v, ack);
            chk({7'h0, ack}, 8'h01);
        end
        m.stop();
    end
    endtask
    task rd(input [1:0] r, input integer n);
        reg [7:0] e;
    begin
        hdr({6'h0, r});
        m.start();
        m.wbyte({4'h7, strap, 1'b1}, ack);
        chk({7'h0, ack}, 8'h01);
        e = (r == 2'h0) ? (ext ^ mreg[2]) : mreg[r];
        for (k = 0; k < n; k = k + 1)
        begin
            m.rbyte(k == n - 1, got);
            chk(got, e);
        end
        m.stop();
    end
    endtask
    // Sampled mid-cycle so the handshake seen is the one the next edge takes
    always @(negedge clk)
        if (wr_valid && ready)
        begin
            nacc = nacc + 8'h01;
            pv = wq.pop_front();
            chk(wr_data, pv);
            if (mptr != 2'h0)
                mreg[mptr] = pv;
        end
    initial
    begin
        nacc = 8'h00;
        mreg[0] = 8'h00;
        mreg[1] = 8'hff;
        mreg[2] = 8'h00;
        mreg[3] = 8'hff;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        seed = lfsr(seed);
        ext = seed[7:0];
        repeat (10) @(posedge clk);
        for (i = 0; i < 8; i = i + 1)
        begin
            #1 strap = i[2:0];
            probe({4'h7, strap + 3'h1}, 1'b0);
            probe({4'h7, strap}, 1'b1);
            @(posedge clk);
        end
        for (i = 0; i < 4; i = i + 1)
            rd(i[1:0], 1);
        for (i = 1; i < 3; i = i + 1)
        begin
            wr({6'h0, i[1:0]}, 1, 8'h00, 1'b0);
            rd(i[1:0], 3);
        end
        chk(p_out, mreg[1]);
        wr(8'h00, 2, 8'h00, 1'b0);
        rd(2'h0, 2);
        wr(8'h03, 1, 8'h00, 1'b1);
        chk(p_oe_n, 8'h00);
        chk(pin, p_out);
        wr(8'h03, 1, 8'hff, 1'b1);
        rd(2'h0, 1);
        wr(8'h01, 0, 8'h00, 1'b0);
        repeat (20) @(posedge clk);
        #1 chk({7'h0, int_oe_n}, 8'h01);
        ext = ext ^ 8'h81;
        repeat (20) @(posedge clk);
        #1 chk({7'h0, int_oe_n}, 8'h00);
        rd(2'h0, 1);
        repeat (20) @(posedge clk);
        #1 chk({7'h0, int_oe_n}, 8'h01);
        // Stalled consumer: only the first sixteen bytes may survive
        ready = 1'b0;
        base = nacc;
        wr(8'h01, 18, 8'h00, 1'b0);
        chk({7'h0, wr_valid}, 8'h01);
        @(posedge clk);
        #1 ready = 1'b1;
        repeat (40) @(posedge clk);
        chk(nacc - base, 8'h10);
        chk(p_out, mreg[1]);
        rd(2'h1, 1);
        stop_test;
    end
    initial
    begin
        #2500000;
        fails = fails + 1;
        stop_test;
    end
endmodule
